// >>> rtl/ssc_lock_mux.sv
// lock indication select with powered-down sections forced high
`timescale 1ns/100ps
module ssc_lock_mux
    import ssc_pkg::*;
(
    input  wire ssc_lock_t  lockIn,
    input  wire logic       mainOn,
    input  wire logic       auxOn,
    input  wire logic       offsetOn,
    input  wire logic [1:0] lockSel,
    output logic            lockOut
);
    logic mainL;
    logic auxL;
    logic offL;

    always_comb begin
        // a sleeping section must not hold off the combined lock
        mainL = lockIn.mainLock | ~mainOn;
        auxL  = lockIn.auxLock | ~auxOn;
        offL  = lockIn.offsetLock | ~offsetOn;
        case (lockSel)
            2'b00:   lockOut = mainL & auxL & offL;
            2'b01:   lockOut = mainL & auxL;
            2'b10:   lockOut = mainL;
            2'b11:   lockOut = auxL;
            default: lockOut = 1'b0;
        endcase
    end
endmodule : ssc_lock_mux

// >>> rtl/ssc_map.svh
// offsets, field positions, reset values and decode constants for serial control
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

`define SSC_WORD_W        24
`define SSC_ADDR2_HI      23
`define SSC_ADDR2_LO      22
`define SSC_ADDR_A        2'h0
`define SSC_ADDR_B        2'h1
`define SSC_ADDR_C        2'h2
`define SSC_ADDR3_LO      21
`define SSC_ADDR_D        3'h6

`define SSC_A_FMOD        21
`define SSC_A_NF_HI       20
`define SSC_A_NF_LO       18
`define SSC_A_MAIN_HI     17
`define SSC_A_MAIN_LO     2

`define SSC_B_FDAC_HI     21
`define SSC_B_FDAC_LO     14
`define SSC_B_REF_HI      13
`define SSC_B_REF_LO      4

`define SSC_C_AUX_HI      21
`define SSC_C_AUX_LO      8
`define SSC_C_CP_HI       7
`define SSC_C_CP_LO       6
`define SSC_C_LOCK_HI     5
`define SSC_C_LOCK_LO     4
`define SSC_C_PD1         3
`define SSC_C_PD2         2

`define SSC_D_GAIN_HI     20
`define SSC_D_GAIN_LO     13
`define SSC_D_M_HI        12
`define SSC_D_M_LO        11
`define SSC_D_SE          10
`define SSC_D_TM          9
`define SSC_D_AD          8
`define SSC_D_SM1         7
`define SSC_D_SM2         6

`define SSC_MOD_EIGHT     4'h8
`define SSC_MOD_FIVE      4'h5
`define SSC_M_BASE        4'h6
`define SSC_GAIN_STEP_CDB 13'h0012
`define SSC_MAIN_MIN      16'h0200
`define SSC_REF_MIN       10'h004
`define SSC_AUX_MIN       14'h0080

`define SSC_RST_WORD      24'h000000
`define SSC_RST_CFG       '0

`endif

// >>> rtl/ssc_pkg.sv
// types shared by the serial control block
package ssc_pkg;
    typedef struct packed {
        logic        fracModSel;
        logic [2:0]  fracIncrement;
        logic [15:0] mainDivRatio;
        logic [7:0]  fracDac;
        logic [9:0]  refDivRatio;
        logic [13:0] auxDivRatio;
        logic [1:0]  pumpRatio;
        logic [1:0]  lockSel;
        logic        mainPathPowerBit;
        logic        auxPathPowerBit;
        logic [7:0]  txGainStep;
        logic [1:0]  offsetLoopDivisor;
        logic        txShiftLoopOn;
        logic        txStandardSel;
        logic        outputLinearitySel;
        logic        txLoBufferOn;
        logic        refclkBufferOn;
    } ssc_cfg_t;

    typedef struct packed {
        logic mainLock;
        logic auxLock;
        logic offsetLock;
    } ssc_lock_t;

    typedef enum logic [1:0] {
        SSC_SEQ_IDLE = 2'b00,
        SSC_SEQ_SYNTH = 2'b01,
        SSC_SEQ_TX    = 2'b10
    } ssc_seq_t;
endpackage : ssc_pkg

// >>> rtl/ssc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module ssc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstSync_n,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_q;

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule : ssc_sync

// >>> rtl/ssc_top.sv
// serial programming, decode and offset synthesizer enable logic
`timescale 1ns/100ps
`include "ssc_map.svh"

// Overview of operation
// - modulus 8 when select 0, else 5
// - main ratio 16 bits, valid 512..65535
// - ref ratio 10 bits, valid 4..1023
// - aux ratio 14 bits, valid from 128
// - main power bit off; ref off both
// - aux power bit off stops aux path
// - gain step is 0.18 dB attenuation each
// - offset divisor codes give 6 to 9
// - standard select 0 means dual mode
// - linearity select 1 digital, 0 analog
// - buffer enables follow their sleep bits
// - shift loop bit turns offset synth on while synth runs
// - lock mux picks one of four conditions
// - powered-down section reports lock high
// - shift on leading edge, lsb first
// - strobe rise with address loads registers
// - strobe fall on d word sets run
// - transmit enable rise starts modulator only
// - transmit enable fall clears run, modulator and offset loop
// - d word with strobe copies temp register
// - one load pulse per strobe high period
// - shift only while strobe low
// - main word waits for divider sync pulse
module ssc_top
    import ssc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       serClk,
    input  wire logic       serData,
    input  wire logic       serStrobe,
    input  wire logic       txEnable,
    input  wire logic       mainSyncPulse,
    input  wire ssc_lock_t  lockIn,
    output ssc_cfg_t        cfg_q,
    output logic [3:0]      fracModulus_q,
    output logic [3:0]      offsetDivide_q,
    output logic [12:0]     attenCentiDb_q,
    output logic            mainRatioValid_q,
    output logic            refRatioValid_q,
    output logic            auxRatioValid_q,
    output logic            mainPowerOn_q,
    output logic            auxPowerOn_q,
    output logic            refPowerOn_q,
    output logic            dualMode_q,
    output logic            digitalMode_q,
    output logic            txLoBufOn_q,
    output logic            refClkBufOn_q,
    output logic            offsetLoopOn_q,
    output logic            synthRun_q,
    output logic            modulatorOn_q,
    output logic            speedUp_q,
    output logic            lockOut_q
);
    logic                  rstMeta_q;
    logic                  rstSync_n;
    logic [4:0]            pinSync;
    logic                  sclkS;
    logic                  sdataS;
    logic                  strbS;
    logic                  txEnS;
    logic                  mSyncS;
    logic                  sclkPrev_q;
    logic                  strbPrev_q;
    logic                  txEnPrev_q;
    logic [`SSC_WORD_W-1:0] shift_q;
    logic                  loaded_q;
    logic                  aPending_q;
    logic [7:0]            tempFdac_q;
    ssc_cfg_t              cfg_d;
    ssc_seq_t              seq_q;
    logic                  sclkRise;
    logic                  strbRise;
    logic                  strbFall;
    logic                  txEnRise;
    logic                  txEnFall;
    logic                  loadPulse;
    logic                  isA;
    logic                  isB;
    logic                  isC;
    logic                  isD;
    logic                  aCommit;
    logic                  lockMux;
    ssc_lock_t             lockS;
    logic [2:0]            lockSync;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    ssc_sync #(.W(5)) pinSyncU (
        .mclk      (mclk),
        .rstSync_n (rstSync_n),
        .asyncIn   ({mainSyncPulse, txEnable, serStrobe, serData, serClk}),
        .syncOut   (pinSync)
    );

    ssc_sync #(.W(3)) lockSyncU (
        .mclk      (mclk),
        .rstSync_n (rstSync_n),
        .asyncIn   (lockIn),
        .syncOut   (lockSync)
    );

    assign sclkS  = pinSync[0];
    assign sdataS = pinSync[1];
    assign strbS  = pinSync[2];
    assign txEnS  = pinSync[3];
    assign mSyncS = pinSync[4];
    assign lockS  = ssc_lock_t'(lockSync);

    function automatic logic addrIs2(input logic [`SSC_WORD_W-1:0] w, input logic [1:0] a);
        return w[`SSC_ADDR2_HI:`SSC_ADDR2_LO] == a;
    endfunction : addrIs2

    // edge detectors read only second-stage outputs
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclkPrev_q <= 1'b0;
            strbPrev_q <= 1'b0;
            txEnPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
            strbPrev_q <= strbS;
            txEnPrev_q <= txEnS;
        end
    end

    assign sclkRise = sclkS & ~sclkPrev_q;
    assign strbRise = strbS & ~strbPrev_q;
    assign strbFall = ~strbS & strbPrev_q;
    assign txEnRise = txEnS & ~txEnPrev_q;
    assign txEnFall = ~txEnS & txEnPrev_q;

    assign isA = addrIs2(shift_q, `SSC_ADDR_A);
    assign isB = addrIs2(shift_q, `SSC_ADDR_B);
    assign isC = addrIs2(shift_q, `SSC_ADDR_C);
    assign isD = shift_q[`SSC_ADDR2_HI:`SSC_ADDR3_LO] == `SSC_ADDR_D;

    // shift register: new bit enters at the top so the first bit ends at p0
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            shift_q <= `SSC_RST_WORD;
        end else if (sclkRise && !strbS) begin
            shift_q <= {sdataS, shift_q[`SSC_WORD_W-1:1]};
        end
    end

    // one load per strobe high, even if stray bits re-trigger the decode
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            loaded_q <= 1'b0;
        end else if (!strbS) begin
            loaded_q <= 1'b0;
        end else if (loadPulse) begin
            loaded_q <= 1'b1;
        end
    end

    assign loadPulse = strbRise & ~loaded_q;

    // main word waits for the divider terminal-count pulse to avoid a phase jump
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            aPending_q <= 1'b0;
        end else if (aCommit || !strbS) begin
            aPending_q <= 1'b0;
        end else if (loadPulse && isA) begin
            aPending_q <= 1'b1;
        end
    end

    assign aCommit = aPending_q & mSyncS & strbS;

    // temporary register shared by the synthesizers
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            tempFdac_q <= 8'h00;
        end else if (loadPulse && isB) begin
            tempFdac_q <= shift_q[`SSC_B_FDAC_HI:`SSC_B_FDAC_LO];
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        if (aCommit) begin
            cfg_d.fracModSel    = shift_q[`SSC_A_FMOD];
            cfg_d.fracIncrement = shift_q[`SSC_A_NF_HI:`SSC_A_NF_LO];
            cfg_d.mainDivRatio  = shift_q[`SSC_A_MAIN_HI:`SSC_A_MAIN_LO];
            cfg_d.fracDac       = tempFdac_q;
        end
        if (loadPulse && isB) begin
            cfg_d.refDivRatio = shift_q[`SSC_B_REF_HI:`SSC_B_REF_LO];
        end
        if (loadPulse && isC) begin
            cfg_d.auxDivRatio      = shift_q[`SSC_C_AUX_HI:`SSC_C_AUX_LO];
            cfg_d.pumpRatio        = shift_q[`SSC_C_CP_HI:`SSC_C_CP_LO];
            cfg_d.lockSel          = shift_q[`SSC_C_LOCK_HI:`SSC_C_LOCK_LO];
            cfg_d.mainPathPowerBit = shift_q[`SSC_C_PD1];
            cfg_d.auxPathPowerBit  = shift_q[`SSC_C_PD2];
        end
        if (loadPulse && isD) begin
            cfg_d.txGainStep         = shift_q[`SSC_D_GAIN_HI:`SSC_D_GAIN_LO];
            cfg_d.offsetLoopDivisor  = shift_q[`SSC_D_M_HI:`SSC_D_M_LO];
            cfg_d.txShiftLoopOn      = shift_q[`SSC_D_SE];
            cfg_d.txStandardSel      = shift_q[`SSC_D_TM];
            cfg_d.outputLinearitySel = shift_q[`SSC_D_AD];
            cfg_d.txLoBufferOn       = shift_q[`SSC_D_SM1];
            cfg_d.refclkBufferOn     = shift_q[`SSC_D_SM2];
            cfg_d.fracDac            = tempFdac_q;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cfg_q <= `SSC_RST_CFG;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // decoded values follow the working registers one cycle later
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fracModulus_q    <= `SSC_MOD_EIGHT;
            offsetDivide_q   <= `SSC_M_BASE;
            attenCentiDb_q   <= 13'h0000;
            mainRatioValid_q <= 1'b0;
            refRatioValid_q  <= 1'b0;
            auxRatioValid_q  <= 1'b0;
        end else begin
            fracModulus_q    <= cfg_q.fracModSel ? `SSC_MOD_FIVE : `SSC_MOD_EIGHT;
            offsetDivide_q   <= `SSC_M_BASE + {2'h0, cfg_q.offsetLoopDivisor};
            attenCentiDb_q   <= 13'({5'h00, cfg_q.txGainStep} * `SSC_GAIN_STEP_CDB);
            mainRatioValid_q <= cfg_q.mainDivRatio >= `SSC_MAIN_MIN;
            refRatioValid_q  <= cfg_q.refDivRatio >= `SSC_REF_MIN;
            auxRatioValid_q  <= cfg_q.auxDivRatio >= `SSC_AUX_MIN;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mainPowerOn_q  <= 1'b0;
            auxPowerOn_q   <= 1'b0;
            refPowerOn_q   <= 1'b0;
            dualMode_q     <= 1'b0;
            digitalMode_q  <= 1'b0;
            txLoBufOn_q    <= 1'b0;
            refClkBufOn_q  <= 1'b0;
            offsetLoopOn_q <= 1'b0;
        end else begin
            mainPowerOn_q  <= cfg_q.mainPathPowerBit;
            auxPowerOn_q   <= cfg_q.auxPathPowerBit;
            refPowerOn_q   <= cfg_q.mainPathPowerBit | cfg_q.auxPathPowerBit;
            dualMode_q     <= ~cfg_q.txStandardSel;
            digitalMode_q  <= cfg_q.outputLinearitySel;
            txLoBufOn_q    <= cfg_q.txLoBufferOn;
            refClkBufOn_q  <= cfg_q.refclkBufferOn;
            offsetLoopOn_q <= cfg_q.txShiftLoopOn & synthRun_q;
        end
    end

    // transmit sequence: d-word strobe fall arms synth, enable fall clears all
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            seq_q <= SSC_SEQ_IDLE;
        end else begin
            case (seq_q)
                SSC_SEQ_IDLE: begin
                    if (strbFall && isD) begin
                        seq_q <= SSC_SEQ_SYNTH;
                    end
                end
                SSC_SEQ_SYNTH: begin
                    if (txEnFall) begin
                        seq_q <= SSC_SEQ_IDLE;
                    end else if (txEnRise) begin
                        seq_q <= SSC_SEQ_TX;
                    end
                end
                SSC_SEQ_TX: begin
                    if (txEnFall) begin
                        seq_q <= SSC_SEQ_IDLE;
                    end
                end
                default: seq_q <= SSC_SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            synthRun_q    <= 1'b0;
            modulatorOn_q <= 1'b0;
        end else begin
            synthRun_q    <= seq_q != SSC_SEQ_IDLE;
            modulatorOn_q <= seq_q == SSC_SEQ_TX;
        end
    end

    // speed-up runs from main word commit until strobe drops
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            speedUp_q <= 1'b0;
        end else if (!strbS) begin
            speedUp_q <= 1'b0;
        end else if (aCommit) begin
            speedUp_q <= 1'b1;
        end
    end

    ssc_lock_mux lockMuxU (
        .lockIn   (lockS),
        .mainOn   (cfg_q.mainPathPowerBit),
        .auxOn    (cfg_q.auxPathPowerBit),
        .offsetOn (cfg_q.txShiftLoopOn & synthRun_q),
        .lockSel  (cfg_q.lockSel),
        .lockOut  (lockMux)
    );

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lockOut_q <= 1'b0;
        end else begin
            lockOut_q <= lockMux;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_n);

    shift_lsb_a: assert property (sclkRise && !strbS |=> shift_q[23] == $past(sdataS))
        else $error("shift register missed incoming bit");
    shift_hold_a: assert property (strbS |=> $stable(shift_q))
        else $error("shift register moved while strobe high");
    one_load_a: assert property (loadPulse |=> !loadPulse throughout strbS[*3])
        else $error("second load during one strobe");
    c_load_a: assert property (loadPulse && isC |=> cfg_q.lockSel == $past(shift_q[5:4]))
        else $error("c word not loaded on strobe rise");
    a_sync_a: assert property ($changed(cfg_q.mainDivRatio) |-> $past(mSyncS))
        else $error("main ratio loaded without sync pulse");
    keep_a: assert property (loadPulse && isB |=> $stable(cfg_q.auxDivRatio))
        else $error("unaddressed register changed");
    run_set_a: assert property (strbFall && isD |-> ##2 synthRun_q)
        else $error("synth run not set by d word");
    run_clr_a: assert property (txEnFall |-> ##2 !synthRun_q && !modulatorOn_q)
        else $error("enable fall did not clear");
    tx_rise_a: assert property (txEnRise && synthRun_q |-> ##2 synthRun_q)
        else $error("enable rise changed synth run");
    mod_sel_a: assert property (##1 fracModulus_q == ($past(cfg_q.fracModSel) ? 4'h5 : 4'h8))
        else $error("wrong fractional modulus");
    ref_pwr_a: assert property (##1 refPowerOn_q ==
        $past(cfg_q.mainPathPowerBit | cfg_q.auxPathPowerBit))
        else $error("ref divider power wrong");
    lock_pd_a: assert property (!cfg_q.mainPathPowerBit &&
        cfg_q.lockSel == 2'b10 |=> lockOut_q)
        else $error("powered down main not forced locked");

    load_d_c: cover property (loadPulse && isD);
    a_commit_c: cover property (aCommit);
    tx_cycle_c: cover property (modulatorOn_q ##[1:100] !synthRun_q);
endmodule : ssc_top

// >>> sim/ssc_host_model.sv
// host side model driving the three-wire programming link
`timescale 1ns/100ps
module ssc_host_model (
    input  wire logic mclk,
    output logic      serClk,
    output logic      serData,
    output logic      serStrobe
);
    initial begin
        serClk    = 1'b0;
        serData   = 1'b0;
        serStrobe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // 80 ns serial period; clock idles low between frames
    task automatic pulse(input logic d);
        serData = d;
        tick(4);
        serClk = 1'b1;
        tick(4);
        serClk = 1'b0;
    endtask : pulse

    // strobe is left high so the bench can look while it stands
    task automatic send(input logic [23:0] w);
        for (int i = 0; i < 24; i++) begin
            pulse(w[i]);
        end
        serStrobe = 1'b1;
        serData   = ~serData;
        tick(12);
    endtask : send

    // stray clocks while strobe is high must not shift
    task automatic junk(input int n);
        for (int i = 0; i < n; i++) begin
            pulse(i[0]);
        end
    endtask : junk

    task automatic drop();
        serStrobe = 1'b0;
        serData   = ~serData;
        tick(12);
    endtask : drop

    task automatic restrobe();
        serStrobe = 1'b1;
        tick(12);
    endtask : restrobe
endmodule : ssc_host_model

// >>> sim/tb_top.sv
// self-checking bench for the serial control block
`timescale 1ns/100ps
module tb_top;
    import ssc_pkg::*;
    logic        mclk, rst_n, serClk, serData, serStrobe, txEnable, mainSyncPulse;
    ssc_lock_t   lockIn;
    ssc_cfg_t    cfg_q;
    logic [3:0]  fracMod, offDiv;
    logic [12:0] atten;
    logic        mainOk, refOk, auxOk, mainOn, auxOn, refOn, dual, digital;
    logic        loBuf, refBuf, offOn, run, modOn, speedUp, lockOut;
    int          bad_count = 0;
    int          total_checks = 0;

    ssc_top DUT (.mclk(mclk), .rst_n(rst_n), .serClk(serClk), .serData(serData),
        .serStrobe(serStrobe), .txEnable(txEnable), .mainSyncPulse(mainSyncPulse),
        .lockIn(lockIn), .cfg_q(cfg_q), .fracModulus_q(fracMod), .offsetDivide_q(offDiv),
        .attenCentiDb_q(atten), .mainRatioValid_q(mainOk), .refRatioValid_q(refOk),
        .auxRatioValid_q(auxOk), .mainPowerOn_q(mainOn), .auxPowerOn_q(auxOn),
        .refPowerOn_q(refOn), .dualMode_q(dual), .digitalMode_q(digital),
        .txLoBufOn_q(loBuf), .refClkBufOn_q(refBuf), .offsetLoopOn_q(offOn),
        .synthRun_q(run), .modulatorOn_q(modOn), .speedUp_q(speedUp), .lockOut_q(lockOut));
    ssc_host_model host (.mclk(mclk), .serClk(serClk), .serData(serData),
        .serStrobe(serStrobe));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    function automatic logic [23:0] cw(logic [13:0] aux, logic [1:0] ls, logic p1, logic p2);
        return {2'b10, aux, 2'b00, ls, p1, p2, 2'b00};
    endfunction : cw

    task automatic t_power();
        lockIn = '0;
        host.send(cw(14'h0080, 2'b11, 1'b1, 1'b0));
        check(cfg_q.auxDivRatio, 24'h80);
        check(auxOk, 24'h1);
        check({mainOn, auxOn, refOn}, 24'h5);
        check(lockOut, 24'h1);
        host.drop();
        host.send(cw(14'h007f, 2'b10, 1'b0, 1'b0));
        check(auxOk, 24'h0);
        check({mainOn, auxOn, refOn}, 24'h0);
        check(lockOut, 24'h1);
        host.drop();
        $display("test power done");
    endtask : t_power

    // main locked only; offset section is off, so it reads locked
    task automatic t_lock();
        logic [3:0] exp;
        exp    = 4'b0100;
        lockIn = 3'b100;
        for (int s = 0; s < 4; s++) begin
            host.send(cw(14'h3fff, s[1:0], 1'b1, 1'b1));
            check(lockOut, exp[s]);
            host.drop();
        end
        $display("test lock done");
    endtask : t_lock

    task automatic t_dword();
        logic [4:0] b;
        logic [7:0] g;
        for (int k = 0; k < 4; k++) begin
            b = k[0] ? 5'b10101 : 5'b01010;
            g = 8'(k * 85);
            host.send({3'b110, g, k[1:0], b, 6'h00});
            check(offDiv, 24'(6 + k));
            check(atten, 24'(k * 1530));
            check({dual, digital, loBuf, refBuf}, {20'h0, ~b[3], b[2:0]});
            host.drop();
            check(run, 24'h1);
            check(offOn, {23'h0, b[4]});
        end
        txEnable = 1'b1;
        wait_n(12);
        check({run, modOn}, 24'h3);
        txEnable = 1'b0;
        wait_n(12);
        check({run, modOn, offOn}, 24'h0);
        $display("test dword done");
    endtask : t_dword

    task automatic t_aword();
        host.send({2'b01, 8'h5a, 10'h004, 4'h0});
        host.drop();
        check(cfg_q.refDivRatio, 24'h4);
        check(refOk, 24'h1);
        check(cfg_q.mainDivRatio, 24'h0);
        host.send({2'b00, 1'b1, 3'h5, 16'h0200, 2'b00});
        check(cfg_q.mainDivRatio, 24'h0);
        host.drop();
        check(cfg_q.mainDivRatio, 24'h0);
        mainSyncPulse = 1'b1;
        host.send({2'b00, 1'b1, 3'h5, 16'h0200, 2'b00});
        check(cfg_q.mainDivRatio, 24'h200);
        check({mainOk, fracMod}, 24'h15);
        check(cfg_q.fracDac, 24'h5a);
        check(speedUp, 24'h1);
        check(cfg_q.auxDivRatio, 24'h3fff);
        host.drop();
        mainSyncPulse = 1'b0;
        check(speedUp, 24'h0);
        $display("test aword done");
    endtask : t_aword

    // garbage clocks during strobe high; a re-strobe reloads the same word
    task automatic t_hold();
        host.send(cw(14'h1234, 2'b00, 1'b1, 1'b1));
        host.junk(6);
        check(cfg_q.auxDivRatio, 24'h1234);
        host.drop();
        host.restrobe();
        check(cfg_q.auxDivRatio, 24'h1234);
        host.drop();
        $display("test hold done");
    endtask : t_hold

    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        close_out();
    end

    initial begin
        rst_n         = 1'b0;
        txEnable      = 1'b0;
        mainSyncPulse = 1'b0;
        lockIn        = '0;
        wait_n(8);
        rst_n = 1'b1;
        wait_n(10);
        check(fracMod, 24'h8);
        check(offDiv, 24'h6);
        check({run, modOn, speedUp}, 24'h0);
        $display("test reset done");
        t_power();
        t_lock();
        t_dword();
        t_aword();
        t_hold();
        close_out();
    end
endmodule : tb_top
